// file: bps_pkg.sv
// Constants, types and field layouts shared by the buck protection sequencer.
// Contract
// R1: Overcurrent: high off, low on until cycle.
// R2: Trip strap selects threshold and discharge.
// R3: Powergood held low until soft start ends.
// R4: Powergood rises after 1ms inside window.
// R5: Powergood falls 1.5us after leaving window.
// R6: Enable low with discharge: discharge switch on.
// R7: Enable rise ends discharge, soft start follows.
// R8: Overvoltage latches low-side on, other off.
// R9: Undervoltage 1ms latches drivers off, both.
// R10: Undervoltage detection waits for soft start.
// R11: Latches clear on enable toggles or lockout.
// R12: Function strap selects overvoltage and mode.
// R13: Supply lockouts gate outputs without latching.
// R14: Overtemperature stops channels, five volt, limit.
// R15: Leaving tight window restarts powergood timer.
// R16: Recovery above threshold restarts undervoltage timer.
package bps_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_HZ = 25_000_000;
   localparam int PG_RISE_MS = 1;
   localparam int PG_FALL_NS = 1500;
   localparam int UV_DELAY_MS = 1;
   localparam logic [15:0] PG_RISE_CYC = 16'(PG_RISE_MS * (CLK_HZ / 1000));
   localparam logic [15:0] PG_FALL_CYC =
      16'((PG_FALL_NS * (CLK_HZ / 1000)) / 1_000_000);
   localparam logic [15:0] UV_DELAY_CYC = 16'(UV_DELAY_MS * (CLK_HZ / 1000));

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam logic [2:0] CONTROL_RESET = 3'h0;
   localparam int CTRL_MASTER = 0;
   localparam int CTRL_CH_ONE = 1;
   localparam int CTRL_CH_TWO = 2;

   ////////////////////////////////////////////////////////////////////////
   // Four-level strap encodings.
   localparam logic [1:0] LVL_GROUND = 2'h0;
   localparam logic [1:0] LVL_REFERENCE = 2'h1;
   localparam logic [1:0] LVL_THREE_VOLT = 2'h2;
   localparam logic [1:0] LVL_FIVE_VOLT = 2'h3;

   typedef enum logic [1:0] {ch_off, ch_soft, ch_run} bps_chan_e;

   typedef struct packed {
      logic soft_start_done;
      logic in_tight_window;
      logic out_wide_window;
      logic over_voltage;
      logic under_voltage;
      logic over_current;
      logic ss_above_output;
      logic cycle_start;
   } bps_sense_s;

   typedef struct packed {
      logic five_lock;
      logic three_lock;
      logic ref_lock;
      logic over_temp;
   } bps_supply_s;

   typedef struct packed {
      logic high_on;
      logic low_on;
      logic discharge_on;
      logic powergood;
      logic soft_start_run;
   } bps_drive_s;

   typedef struct packed {
      logic five_volt_regulator_on;
      logic two_volt_reference_on;
      logic three_volt_limit_low;
   } bps_rails_s;

   typedef struct packed {
      logic low_trip_threshold;
      logic discharge_enable;
      logic overvoltage_enable;
      logic current_mode;
   } bps_cfg_s;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bps_avs_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } bps_avs_rsp_s;

endpackage

// file: bps_delay_timer.sv
// Qualification timer: reports a condition held for an uninterrupted span.
`timescale 1ns/100ps
module bps_delay_timer #(
   parameter logic [15:0] CYCLES = 16'h0001
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_cond,
   output logic o_done
);

   typedef struct packed {
      logic [15:0] cnt;
      logic done;
   } bps_tmr_s;

   bps_tmr_s st;
   bps_tmr_s next_st;

   // Any gap in the condition restarts the span from zero.
   always_comb begin
      next_st = st;
      if (!i_cond) begin
         next_st = '0;
      end else if (!st.done) begin
         next_st.cnt = st.cnt + 16'h0001;
         next_st.done = (st.cnt == CYCLES - 16'h0001);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_done = st.done;

endmodule

// file: bps_strap_decode.sv
// Strap capture and decode for the trip and function straps.
`timescale 1ns/100ps
module bps_strap_decode (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic [1:0] i_trip_strap,
   input wire logic [1:0] i_function_strap,
   output bps_pkg::bps_cfg_s o_cfg
);

   typedef struct packed {
      logic captured;
      bps_pkg::bps_cfg_s cfg;
   } bps_strap_s;

   bps_strap_s st;
   bps_strap_s next_st;

   // Straps are sampled once, on the first edge after reset release.
   always_comb begin
      next_st = st;
      if (!st.captured) begin
         next_st.captured = 1'b1;
         next_st.cfg.low_trip_threshold =
            (i_trip_strap == bps_pkg::LVL_THREE_VOLT) ||
            (i_trip_strap == bps_pkg::LVL_FIVE_VOLT); // [R2]
         next_st.cfg.discharge_enable =
            (i_trip_strap == bps_pkg::LVL_GROUND) ||
            (i_trip_strap == bps_pkg::LVL_FIVE_VOLT); // [R2]
         next_st.cfg.overvoltage_enable =
            (i_function_strap == bps_pkg::LVL_GROUND) ||
            (i_function_strap == bps_pkg::LVL_THREE_VOLT); // [R12]
         next_st.cfg.current_mode =
            (i_function_strap == bps_pkg::LVL_GROUND) ||
            (i_function_strap == bps_pkg::LVL_FIVE_VOLT); // [R12]
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_cfg = st.cfg;

endmodule

// file: bps_sequencer.sv
// Two-channel buck protection, powergood and sequencing logic.
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module bps_sequencer #(
   parameter logic [15:0] PG_RISE_CYCLES = bps_pkg::PG_RISE_CYC,
   parameter logic [15:0] UV_DELAY_CYCLES = bps_pkg::UV_DELAY_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire bps_pkg::bps_avs_req_s i_avs,
   output bps_pkg::bps_avs_rsp_s o_avs,
   input wire bps_pkg::bps_sense_s [1:0] i_sense,
   input wire bps_pkg::bps_supply_s i_supply,
   input wire logic [1:0] i_trip_strap,
   input wire logic [1:0] i_function_strap,
   output bps_pkg::bps_drive_s [1:0] o_drive,
   output bps_pkg::bps_rails_s o_rails,
   output bps_pkg::bps_cfg_s o_cfg
);

   ////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [2:0] control;
      bps_pkg::bps_chan_e [1:0] chan;
      logic [1:0] switching;
      logic [1:0] oc_hold;
      logic [1:0] ov_latch;
      logic [1:0] uv_latch;
      bps_pkg::bps_drive_s [1:0] drive;
      bps_pkg::bps_rails_s rails;
      logic ack;
      logic [31:0] readdata;
   } bps_state_s;

   bps_state_s st;
   bps_state_s next_st;

   bps_pkg::bps_cfg_s cfg;
   logic [1:0] pg_rise_cond;
   logic [1:0] pg_fall_cond;
   logic [1:0] uv_cond;
   logic [1:0] pg_rise_done;
   logic [1:0] pg_fall_done;
   logic [1:0] uv_done;

   ////////////////////////////////////////////////////////////////////////
   // Straps.

   bps_strap_decode u_strap (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_trip_strap(i_trip_strap),
      .i_function_strap(i_function_strap),
      .o_cfg(cfg)
   );

   ////////////////////////////////////////////////////////////////////////
   // Per-channel timers.

   // Powergood uses the tight window to rise and the wide window to
   // fall; the gap between them gives hysteresis against ripple.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         assign pg_rise_cond[g] = (st.chan[g] == bps_pkg::ch_run) &&
            i_sense[g].in_tight_window; // [R3] [R15]
         assign pg_fall_cond[g] = i_sense[g].out_wide_window; // [R5]
         assign uv_cond[g] = (st.chan[g] == bps_pkg::ch_run) &&
            i_sense[g].under_voltage; // [R10] [R16]

         bps_delay_timer #(
            .CYCLES(PG_RISE_CYCLES)
         ) u_pg_rise (
            .i_sys_clk(i_sys_clk),
            .i_srst(i_srst),
            .i_cond(pg_rise_cond[g]),
            .o_done(pg_rise_done[g])
         );

         bps_delay_timer #(
            .CYCLES(bps_pkg::PG_FALL_CYC)
         ) u_pg_fall (
            .i_sys_clk(i_sys_clk),
            .i_srst(i_srst),
            .i_cond(pg_fall_cond[g]),
            .o_done(pg_fall_done[g])
         );

         bps_delay_timer #(
            .CYCLES(UV_DELAY_CYCLES)
         ) u_uv (
            .i_sys_clk(i_sys_clk),
            .i_srst(i_srst),
            .i_cond(uv_cond[g]),
            .o_done(uv_done[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      logic master_on;
      logic [1:0] ch_en;
      logic lockout;
      logic fault_any;
      logic fault_clear;
      logic [1:0] active;
      logic [1:0] ov_set;
      logic [1:0] uv_set;
      logic wr_lo;

      next_st = st;
      master_on = st.control[bps_pkg::CTRL_MASTER];
      ch_en[0] = st.control[bps_pkg::CTRL_CH_ONE];
      ch_en[1] = st.control[bps_pkg::CTRL_CH_TWO];
      lockout = i_supply.five_lock || i_supply.three_lock ||
         i_supply.ref_lock; // [R13]
      fault_any = (|st.ov_latch) || (|st.uv_latch);

      // A latched shutdown is released only while the master enable is
      // low, both channel enables are low, or a lockout is present.
      fault_clear = !master_on || (ch_en == 2'b00) ||
         lockout; // [R11]

      for (int c = 0; c < 2; c++) begin
         ov_set[c] = cfg.overvoltage_enable &&
            (st.chan[c] != bps_pkg::ch_off) &&
            i_sense[c].over_voltage; // [R8]
         uv_set[c] = uv_done[c]; // [R9]
      end

      // A new fault beats the clear in the same cycle.
      for (int c = 0; c < 2; c++) begin
         next_st.ov_latch[c] = ov_set[c] ||
            (st.ov_latch[c] && !fault_clear); // [R8] [R11]
         next_st.uv_latch[c] = uv_set[c] ||
            (st.uv_latch[c] && !fault_clear); // [R9] [R11]
      end

      // Lockout and overtemperature gate the channels level by level,
      // so switching resumes by itself once they go away.
      for (int c = 0; c < 2; c++) begin
         active[c] = master_on && ch_en[c] && !lockout &&
            !i_supply.over_temp && !fault_any &&
            !(|ov_set) && !(|uv_set); // [R13] [R14] [R8] [R9]
      end

      ////////////////////////////////////////////////////////////////////
      // Channel sequencing.

      for (int c = 0; c < 2; c++) begin
         case (st.chan[c])
            bps_pkg::ch_off: begin
               next_st.switching[c] = 1'b0;
               if (active[c]) begin
                  next_st.chan[c] = bps_pkg::ch_soft; // [R7]
               end
            end
            bps_pkg::ch_soft: begin
               if (!active[c]) begin
                  next_st.chan[c] = bps_pkg::ch_off;
                  next_st.switching[c] = 1'b0;
               end else begin
                  // Switching waits until the ramp passes what is left
                  // on the output, so a precharged rail is not pulled
                  // down by the low-side switch.
                  if (i_sense[c].ss_above_output) begin
                     next_st.switching[c] = 1'b1; // [R7]
                  end
                  if (i_sense[c].soft_start_done) begin
                     next_st.chan[c] = bps_pkg::ch_run;
                  end
               end
            end
            bps_pkg::ch_run: begin
               if (!active[c]) begin
                  next_st.chan[c] = bps_pkg::ch_off;
                  next_st.switching[c] = 1'b0;
               end
            end
            default: begin
               next_st.chan[c] = bps_pkg::ch_off;
               next_st.switching[c] = 1'b0;
            end
         endcase
      end

      ////////////////////////////////////////////////////////////////////
      // Cycle-by-cycle current limit; a trip on a cycle start still
      // holds through the new cycle.

      for (int c = 0; c < 2; c++) begin
         if (i_sense[c].over_current) begin
            next_st.oc_hold[c] = 1'b1; // [R1]
         end else if (i_sense[c].cycle_start) begin
            next_st.oc_hold[c] = 1'b0; // [R1]
         end
      end

      ////////////////////////////////////////////////////////////////////
      // Gate drive, discharge and powergood.

      for (int c = 0; c < 2; c++) begin
         if (next_st.ov_latch[c]) begin
            next_st.drive[c].high_on = 1'b0; // [R8]
            next_st.drive[c].low_on = 1'b1; // [R8]
         end else if (next_st.uv_latch[c] || fault_any ||
                      (|ov_set) || (|uv_set)) begin
            next_st.drive[c].high_on = 1'b0; // [R9]
            next_st.drive[c].low_on = 1'b0; // [R9]
         end else if (!active[c] || !next_st.switching[c]) begin
            next_st.drive[c].high_on = 1'b0; // [R13] [R14]
            next_st.drive[c].low_on = 1'b0;
         end else if (next_st.oc_hold[c]) begin
            next_st.drive[c].high_on = 1'b0; // [R1]
            next_st.drive[c].low_on = 1'b1; // [R1]
         end else begin
            next_st.drive[c].high_on = 1'b1;
            next_st.drive[c].low_on = 1'b1;
         end

         // The discharge switch is weak, so it may sit on a charged
         // rail for a long time; raising the enable ends it at once.
         next_st.drive[c].discharge_on = !ch_en[c] &&
            cfg.discharge_enable; // [R6] [R7]
         next_st.drive[c].soft_start_run =
            (next_st.chan[c] == bps_pkg::ch_soft); // [R7]

         if (st.chan[c] != bps_pkg::ch_run) begin
            next_st.drive[c].powergood = 1'b0; // [R3]
         end else if (pg_fall_done[c]) begin
            next_st.drive[c].powergood = 1'b0; // [R5]
         end else if (pg_rise_done[c]) begin
            next_st.drive[c].powergood = 1'b1; // [R4]
         end
      end

      ////////////////////////////////////////////////////////////////////
      // Regulator gating.

      next_st.rails.five_volt_regulator_on = !i_supply.three_lock &&
         !i_supply.ref_lock && !i_supply.over_temp; // [R13] [R14]
      next_st.rails.two_volt_reference_on =
         !i_supply.three_lock; // [R13]
      next_st.rails.three_volt_limit_low = i_supply.over_temp; // [R14]

      ////////////////////////////////////////////////////////////////////
      // Register bus: every access is answered on the edge after it is
      // first seen, then the slave waits one cycle before the next.

      wr_lo = i_avs.write && i_avs.byteenable[0];
      next_st.ack = (i_avs.read || i_avs.write) && !st.ack;
      if (next_st.ack) begin
         next_st.readdata = '0;
         if (i_avs.address == bps_pkg::REG_CONTROL) begin
            if (wr_lo) begin
               next_st.control = i_avs.writedata[2:0];
            end
            next_st.readdata[2:0] = st.control;
         end else if (i_avs.address == bps_pkg::REG_STATUS) begin
            next_st.readdata[1:0] = {st.drive[1].powergood,
               st.drive[0].powergood};
            next_st.readdata[3:2] = st.ov_latch;
            next_st.readdata[5:4] = st.uv_latch;
            next_st.readdata[7:6] = st.oc_hold;
            next_st.readdata[9:8] = {st.chan[1] == bps_pkg::ch_run,
               st.chan[0] == bps_pkg::ch_run};
            next_st.readdata[11:10] = {st.chan[1] == bps_pkg::ch_soft,
               st.chan[0] == bps_pkg::ch_soft};
            next_st.readdata[15:12] = i_supply;
         end else if (i_avs.address == bps_pkg::REG_CONFIG) begin
            next_st.readdata[3:0] = cfg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st <= '0;
         st.control <= bps_pkg::CONTROL_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign o_drive = st.drive;
   assign o_rails = st.rails;
   assign o_cfg = cfg;
   assign o_avs.readdata = st.readdata;
   assign o_avs.waitrequest = !st.ack;

endmodule

// file: bps_sequencer_checker.sv
// Port-level assertions for the buck protection sequencer.
`timescale 1ns/100ps
module bps_sequencer_checker #(
   parameter logic [15:0] PG_RISE_CYCLES = 16'h0014,
   parameter logic [15:0] UV_DELAY_CYCLES = 16'h0014
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire bps_pkg::bps_avs_req_s i_avs,
   input wire bps_pkg::bps_avs_rsp_s o_avs,
   input wire bps_pkg::bps_sense_s [1:0] i_sense,
   input wire bps_pkg::bps_supply_s i_supply,
   input wire logic [1:0] i_trip_strap,
   input wire logic [1:0] i_function_strap,
   input wire bps_pkg::bps_drive_s [1:0] o_drive,
   input wire bps_pkg::bps_rails_s o_rails,
   input wire bps_pkg::bps_cfg_s o_cfg
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   logic [15:0] tight_cnt;
   logic [15:0] wide_cnt;
   logic [15:0] uv_cnt;
   logic sw;
   assign sw = o_drive[0].high_on | o_drive[0].low_on;

   ////////////////////////////////////////////////////////////////////////
   // Run lengths of the channel one window and undervoltage inputs.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tight_cnt <= 16'h0000;
         wide_cnt <= 16'h0000;
         uv_cnt <= 16'h0000;
      end else begin
         tight_cnt <= i_sense[0].in_tight_window ? tight_cnt + 16'h0001 : '0;
         wide_cnt <= i_sense[0].out_wide_window ? wide_cnt + 16'h0001 : '0;
         // Soft start is left out because the fault is not armed there.
         uv_cnt <= (i_sense[0].under_voltage && sw &&
            !o_drive[0].soft_start_run) ? uv_cnt + 16'h0001 : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_both_off;
      !o_drive[0].high_on && !o_drive[0].low_on &&
      !o_drive[1].high_on && !o_drive[1].low_on;
   endsequence
   sequence s_ovp_trip;
      i_sense[0].over_voltage && o_cfg.overvoltage_enable &&
      o_drive[0].high_on;
   endsequence
   sequence s_ovp_hold;
      (!o_drive[0].high_on && o_drive[0].low_on &&
      !o_drive[1].high_on && !o_drive[1].low_on) [*3];
   endsequence

   a_trip_decode: assert property ($fell(i_srst) |-> ##3
      (o_cfg.low_trip_threshold == i_trip_strap[1] &&
      o_cfg.discharge_enable == (i_trip_strap[0] == i_trip_strap[1])))
      else $error("trip strap decode wrong");
   a_function_strap_decode: assert property ($fell(i_srst) |-> ##3
      (o_cfg.overvoltage_enable == !i_function_strap[0] &&
      o_cfg.current_mode == (i_function_strap[0] == i_function_strap[1])))
      else $error("function strap decode wrong");
   a_ocl_low_side: assert property (i_sense[0].over_current && sw |=>
      !o_drive[0].high_on && o_drive[0].low_on)
      else $error("low side not forced");
   a_pg_soft_low: assert property (o_drive[0].soft_start_run |->
      !o_drive[0].powergood) else $error("pg in soft start");
   a_pg_rise_delay: assert property ($rose(o_drive[0].powergood) |->
      tight_cnt >= PG_RISE_CYCLES) else $error("powergood rose early");
   a_pg_fall_delay: assert property (wide_cnt >= 16'h0028 |->
      !o_drive[0].powergood) else $error("powergood did not fall");
   a_discharge_gate: assert property (o_drive[0].discharge_on |->
      o_cfg.discharge_enable && !o_drive[0].high_on)
      else $error("bad discharge");
   a_ovp_latch: assert property (s_ovp_trip |=> s_ovp_hold)
      else $error("ov latch wrong");
   a_uv_latch: assert property (uv_cnt <= UV_DELAY_CYCLES + 16'h0003)
      else $error("undervoltage did not latch");
   a_lock_off: assert property (|i_supply[3:1] |-> ##[1:2] s_both_off)
      else $error("lockout leak");
   a_thermal_off: assert property (i_supply.over_temp |->
      ##[1:2] s_both_off) else $error("thermal leak");
   a_rail_follow: assert property (!$past(i_srst) |->
      o_rails.five_volt_regulator_on == !$past(i_supply.three_lock |
      i_supply.ref_lock | i_supply.over_temp) &&
      o_rails.two_volt_reference_on == !$past(i_supply.three_lock) &&
      o_rails.three_volt_limit_low == $past(i_supply.over_temp))
      else $error("rail gating wrong");
endmodule
bind bps_sequencer bps_sequencer_checker #(
   .PG_RISE_CYCLES(PG_RISE_CYCLES),
   .UV_DELAY_CYCLES(UV_DELAY_CYCLES)
) chk_u (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_avs(i_avs),
   .o_avs(o_avs), .i_sense(i_sense), .i_supply(i_supply),
   .i_trip_strap(i_trip_strap), .i_function_strap(i_function_strap),
   .o_drive(o_drive), .o_rails(o_rails), .o_cfg(o_cfg));

// file: bps_gate_model.sv
// Behavioural high-side and low-side gate drivers fed by the sequencer.
`timescale 1ns/100ps
module bps_gate_model (
   input wire logic i_sys_clk,
   input wire bps_pkg::bps_drive_s [1:0] i_drive,
   output logic [1:0] o_gate_high,
   output logic [1:0] o_gate_low
);
   // Gates follow their enables one clock late, which stands in for the
   // propagation delay of a real driver.
   always_ff @(posedge i_sys_clk) begin
      for (int c = 0; c < 2; c++) begin
         o_gate_high[c] <= i_drive[c].high_on;
         o_gate_low[c] <= i_drive[c].low_on;
      end
   end
endmodule

// file: buck_protection_sequencer_tb.sv
// Self-checking bench for the buck protection sequencer.
`timescale 1ns/100ps
module buck_protection_sequencer_tb;
   localparam logic [15:0] PG = 16'h0014;
   localparam logic [15:0] UV = 16'h0014;
   logic clk;
   logic srst;
   bps_pkg::bps_avs_req_s req;
   bps_pkg::bps_avs_rsp_s rsp;
   bps_pkg::bps_sense_s [1:0] sense;
   bps_pkg::bps_supply_s supply;
   logic [1:0] trip;
   logic [1:0] function_strap;
   bps_pkg::bps_drive_s [1:0] drive;
   bps_pkg::bps_rails_s rails;
   bps_pkg::bps_cfg_s cfg;
   logic [1:0] gate_high;
   logic [1:0] gate_low;
   logic [31:0] q;
   logic [3:0] s;
   int miscompares;
   int n_checks;
   // Each row is {trip strap, function strap, expected configuration}.
   logic [7:0] rows [4] = '{8'h50, 8'hAA, 8'hFD, 8'h07};

   bps_sequencer #(.PG_RISE_CYCLES(PG), .UV_DELAY_CYCLES(UV)) dut_u (
      .i_sys_clk(clk), .i_srst(srst), .i_avs(req), .o_avs(rsp),
      .i_sense(sense), .i_supply(supply), .i_trip_strap(trip),
      .i_function_strap(function_strap), .o_drive(drive), .o_rails(rails),
      .o_cfg(cfg));
   bps_gate_model gate_u (.i_sys_clk(clk), .i_drive(drive),
      .o_gate_high(gate_high), .o_gate_low(gate_low));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      n_checks++;
      if (!ok) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic rst();
      @(posedge clk);
      srst <= 1'b1;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      wt(3);
   endtask
   // Only the watchdog ends a wait; data is taken at the answering edge.
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] d, output logic [31:0] rd);
      @(posedge clk);
      req <= '{address: a, read: !wr, write: wr, writedata: d,
         byteenable: 4'hF};
      do @(posedge clk);
      while (rsp.waitrequest !== 1'b0);
      chk(rsp.waitrequest === 1'b0, "bus answer");
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      req = '0;
      sense = '0;
      supply = '0;
      trip = 2'h0;
      function_strap = 2'h0;
      miscompares = 0;
      n_checks = 0;
      for (int r = 0; r < 4; r++) begin
         @(posedge clk);
         trip <= rows[r][7:6];
         function_strap <= rows[r][5:4];
         rst();
         chk(cfg === rows[r][3:0], "strap decode");
         chk(drive[0].discharge_on === rows[r][2], "discharge");
         bus(1'b0, bps_pkg::REG_CONFIG, 32'h0, q);
         chk(q === {28'h0, rows[r][3:0]}, "config read");
      end
      bus(1'b0, bps_pkg::REG_CONTROL, 32'h0, q);
      chk(q === 32'h0, "control reset");
      bus(1'b0, 4'hC, 32'h0, q);
      chk(q === 32'h0, "unmapped read");
      bus(1'b1, bps_pkg::REG_CONTROL, 32'h7, q);
      wt(3);
      chk(drive[0].discharge_on === 1'b0, "discharge end");
      chk(drive[0].soft_start_run === 1'b1, "soft start");
      chk(drive[0].high_on === 1'b0, "early switching");
      @(posedge clk);
      sense[0].ss_above_output <= 1'b1;
      sense[1].ss_above_output <= 1'b1;
      sense[0].in_tight_window <= 1'b1;
      wt(3);
      chk(drive[0].high_on === 1'b1, "no switching");
      wt(PG + 5);
      chk(drive[0].powergood === 1'b0, "pg in soft start");
      @(posedge clk);
      sense[0].soft_start_done <= 1'b1;
      sense[1].soft_start_done <= 1'b1;
      repeat (10) @(posedge clk);
      sense[0].in_tight_window <= 1'b0;
      @(posedge clk);
      sense[0].in_tight_window <= 1'b1;
      wt(PG - 3);
      chk(drive[0].powergood === 1'b0, "pg timer kept");
      wt(6);
      chk(drive[0].powergood === 1'b1, "pg late");
      @(posedge clk);
      sense[0].in_tight_window <= 1'b0;
      sense[0].out_wide_window <= 1'b1;
      wt(30);
      chk(drive[0].powergood === 1'b1, "pg fell early");
      wt(12);
      chk(drive[0].powergood === 1'b0, "pg stuck");
      @(posedge clk);
      sense[0].out_wide_window <= 1'b0;
      sense[0].in_tight_window <= 1'b1;
      sense[0].over_current <= 1'b1;
      @(posedge clk);
      sense[0].over_current <= 1'b0;
      wt(4);
      chk(drive[0].high_on === 1'b0 && drive[0].low_on === 1'b1, "ocl");
      chk(gate_high[0] === 1'b0 && gate_low[0] === 1'b1, "gates");
      @(posedge clk);
      sense[0].cycle_start <= 1'b1;
      @(posedge clk);
      sense[0].cycle_start <= 1'b0;
      wt(3);
      chk(drive[0].high_on === 1'b1, "ocl not released");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         sense[0].under_voltage <= 1'b1;
         repeat (UV - 5) @(posedge clk);
         sense[0].under_voltage <= 1'b0;
      end
      wt(3);
      chk(drive[0].high_on === 1'b1, "uv timer kept");
      @(posedge clk);
      sense[0].under_voltage <= 1'b1;
      wt(UV + 5);
      chk(drive[0].low_on === 1'b0 && drive[1].high_on === 1'b0, "uv");
      @(posedge clk);
      sense[0].under_voltage <= 1'b0;
      wt(5);
      bus(1'b0, bps_pkg::REG_STATUS, 32'h0, q);
      chk(q[5:4] === 2'h1 && drive[0].high_on === 1'b0, "uv held");
      bus(1'b1, bps_pkg::REG_CONTROL, 32'h6, q);
      bus(1'b1, bps_pkg::REG_CONTROL, 32'h7, q);
      wt(5);
      bus(1'b0, bps_pkg::REG_STATUS, 32'h0, q);
      chk(q[5:4] === 2'h0 && drive[0].high_on === 1'b1, "uv clear");
      @(posedge clk);
      sense[0].over_voltage <= 1'b1;
      @(posedge clk);
      sense[0].over_voltage <= 1'b0;
      wt(5);
      chk(drive[0].low_on === 1'b1 && drive[1].low_on === 1'b0, "ovp");
      chk(drive[0].high_on === 1'b0 && drive[1].high_on === 1'b0, "ovp");
      bus(1'b1, bps_pkg::REG_CONTROL, 32'h1, q);
      sense[0].soft_start_done <= 1'b0;
      sense[1].soft_start_done <= 1'b0;
      bus(1'b1, bps_pkg::REG_CONTROL, 32'h7, q);
      wt(5);
      bus(1'b0, bps_pkg::REG_STATUS, 32'h0, q);
      chk(q[3:2] === 2'h0, "ovp clear");
      @(posedge clk);
      sense[0].under_voltage <= 1'b1;
      wt(UV + 5);
      chk(drive[0].high_on === 1'b1, "uv in soft start");
      @(posedge clk);
      sense[0].under_voltage <= 1'b0;
      for (int b = 0; b < 4; b++) begin
         s = 4'h1 << b;
         @(posedge clk);
         supply <= s;
         wt(3);
         chk(drive[0].high_on === 1'b0 && drive[1].low_on === 1'b0, "lock");
         chk(rails === {!(s[2] | s[1] | s[0]), !s[2], s[0]}, "rails");
         @(posedge clk);
         supply <= '0;
      end
      wt(6);
      chk(drive[0].high_on === 1'b1, "no recovery");
      stop_test();
   end
endmodule
